// File: adtr_pkg.sv
/*
  Package for the converter control block: register offsets, field positions,
  reset values, the free-running trigger code and the conversion lengths.
  Assumes an 8-bit register port on the system clock.
*/
// Functional notes
// RULE1: Done flag, control A bit 4, sets when result registers are loaded.
// RULE2: Interrupt request only when done flag, irq enable and global enable set.
// RULE3: Done flag clears when the processor takes the matching vector.
// RULE4: Writing one to the done flag clears it; zero leaves it.
// RULE5: Divider select: codes 0,1 divide by 2, doubling up to 128.
// RULE6: Right justified: bits 9:8 in high register, 7:0 in low.
// RULE7: Left justified: bits 9:2 in high register, 1:0 in low bits 7:6.
// RULE8: Low byte read locks result updates until high byte is read.
// RULE9: Justify bit changes the visible layout at once.
// RULE10: Reserved bits 5 and 3 of control B read back as written.
// RULE11: Trigger select acts only while auto-trigger enable is set.
// RULE12: Auto-trigger starts a conversion on each rising edge of selected flag.
// RULE13: Switching selection from clear to set source counts as rising edge.
// RULE14: Selecting free-running never by itself makes a trigger event.
// RULE15: Trigger codes: free, comparator, ext int0, t0 cmpA, t0 ovf, t1 cmpA/ovf/cmpB.
// RULE16: Pin input-disable bits 3:0 force the pin read bits to zero.
// RULE17: Auto-trigger starts conversions on trigger edge instead of software start.
// RULE18: Clearing converter enable stops the converter and aborts the conversion.
// RULE19: First conversion 25 converter clocks, then 13; start bit reads one meanwhile.
// RULE20: Analog core is a start/result/done handshake on the converter clock.
package adtr_pkg;
  localparam logic [2:0] ADTR_OFS_DIDR   = 3'h1;
  localparam logic [2:0] ADTR_OFS_CTRL_B = 3'h3;
  localparam logic [2:0] ADTR_OFS_RES_L  = 3'h4;
  localparam logic [2:0] ADTR_OFS_RES_H  = 3'h5;
  localparam logic [2:0] ADTR_OFS_CTRL_A = 3'h6;
  localparam logic [7:0] ADTR_RST_REG    = 8'h00;
  // Control A fields
  localparam int ADTR_A_EN    = 7;
  localparam int ADTR_A_START = 6;
  localparam int ADTR_A_AUTO  = 5;
  localparam int ADTR_A_DONE  = 4;
  localparam int ADTR_A_IE    = 3;
  // Control B fields
  localparam int ADTR_B_RSV5  = 5;
  localparam int ADTR_B_LEFT  = 4;
  localparam int ADTR_B_RSV3  = 3;
  localparam logic [7:0] ADTR_B_WMASK = 8'h7f;
  localparam logic [7:0] ADTR_DIDR_WMASK = 8'h3f;
  // Conversion lengths in converter clocks
  localparam logic [4:0] ADTR_FIRST_CYC = 5'h19;
  localparam logic [4:0] ADTR_NORM_CYC  = 5'h0d;
  localparam logic [2:0] ADTR_TRIG_FREE = 3'h0;
  typedef enum logic [1:0] {ADTR_IDLE, ADTR_CONV} adtr_state_t;
endpackage : adtr_pkg

// File: adtr_core.sv
/*
  Converter control: registers, prescaler, auto-trigger, conversion sequencer
  and justified result registers.
  Assumes a processor register port on mclk_i; trigger flags come from logic
  on the same clock; the analog core answers on the converter clock tick.
*/
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module adtr_core
  import adtr_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       global_irq_en_i,
  input  wire logic       vector_ack_i,
  input  wire logic [6:0] trig_flags_i,
  output logic            irq_o,
  output logic            conv_tick_o,
  output logic            core_start_o,
  input  wire logic [9:0] core_result_i,
  input  wire logic       core_done_i,
  input  wire logic [3:0] pin_level_i,
  output logic      [3:0] pin_read_o,
  output logic      [3:0] pin_input_off_o
);
  logic [7:0]  ctrl_b, next_ctrl_b, didr, next_didr;
  logic        en, next_en, auto_en, next_auto_en, done, next_done, ie, next_ie;
  logic [2:0]  psel, next_psel;
  logic [6:0]  pdiv, next_pdiv;
  logic        busy, next_busy, first, next_first, locked, next_locked;
  logic [4:0]  cyc, next_cyc;
  logic [9:0]  result, next_result;
  logic        trig_prev, next_trig_prev, started, next_started;
  logic [2:0]  sel_prev, next_sel_prev;
  logic [3:0]  pin_s1, pin_s2;
  adtr_state_t state, next_state;
  logic        trig_sig, trig_edge, tick, sw_start, start_req, finish;
  logic [6:0]  div_mask;
  logic [7:0]  res_l, res_h, next_rdata;

  // Divide by 2 for codes 0 and 1, doubling after [RULE5]
  always_comb begin
    div_mask = 7'h00;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(psel)) begin
        div_mask[i] = 1'b1;
      end
    end
    div_mask[0] = 1'b1;
  end
  assign tick = en && ((pdiv & div_mask) == div_mask); // [RULE5]

  // Code 0 stands on the done flag so free running retriggers, but
  // switching to it is masked below [RULE15]
  always_comb begin
    unique case (ctrl_b[2:0])
      3'h0: trig_sig = done;
      3'h1: trig_sig = trig_flags_i[0];
      3'h2: trig_sig = trig_flags_i[1];
      3'h3: trig_sig = trig_flags_i[2];
      3'h4: trig_sig = trig_flags_i[3];
      3'h5: trig_sig = trig_flags_i[4];
      3'h6: trig_sig = trig_flags_i[5];
      3'h7: trig_sig = trig_flags_i[6];
    endcase
  end
  // Edge only if selection unchanged or moving to a real source [RULE13] [RULE14]
  assign trig_edge = auto_en && trig_sig && !trig_prev &&
                     !(ctrl_b[2:0] == ADTR_TRIG_FREE && sel_prev != ADTR_TRIG_FREE); // [RULE11] [RULE12]

  assign sw_start  = wr_i && addr_i == ADTR_OFS_CTRL_A && wdata_i[ADTR_A_START];
  assign start_req = (sw_start || trig_edge) && (next_en); // [RULE17]
  assign finish    = state == ADTR_CONV && busy && cyc == 5'h00 && tick && core_done_i;

  always_comb begin
    next_ctrl_b = ctrl_b;
    next_didr   = didr;
    next_en     = en;
    next_auto_en = auto_en;
    next_ie     = ie;
    next_psel   = psel;
    next_done   = done;
    if (wr_i && addr_i == ADTR_OFS_CTRL_B) begin
      next_ctrl_b = wdata_i & ADTR_B_WMASK; // [RULE10] [RULE9]
    end
    if (wr_i && addr_i == ADTR_OFS_DIDR) begin
      next_didr = wdata_i & ADTR_DIDR_WMASK;
    end
    if (wr_i && addr_i == ADTR_OFS_CTRL_A) begin
      next_en      = wdata_i[ADTR_A_EN];
      next_auto_en = wdata_i[ADTR_A_AUTO];
      next_ie      = wdata_i[ADTR_A_IE];
      next_psel    = wdata_i[2:0];
      if (wdata_i[ADTR_A_DONE]) begin
        next_done = 1'b0; // [RULE4]
      end
    end
    if (vector_ack_i) begin
      next_done = 1'b0; // [RULE3]
    end
    if (finish) begin
      next_done = 1'b1; // Set wins over clear [RULE1]
    end
  end

  // Sequencer
  always_comb begin
    next_state   = state;
    next_busy    = busy;
    next_first   = first;
    next_cyc     = cyc;
    next_started = started;
    next_pdiv    = en ? pdiv + 7'h01 : 7'h00;
    next_trig_prev = trig_sig;
    next_sel_prev  = ctrl_b[2:0]; // [RULE14]
    if (!en && next_en) begin
      next_first = 1'b1;
    end
    unique case (state)
      ADTR_IDLE: begin
        if (start_req) begin
          next_state   = ADTR_CONV;
          next_busy    = 1'b1; // [RULE19]
          next_cyc     = (first || (!en && next_en)) ? ADTR_FIRST_CYC - 5'h01 : ADTR_NORM_CYC - 5'h01;
          next_started = 1'b0;
        end
      end
      ADTR_CONV: begin
        if (tick) begin
          next_started = 1'b1; // [RULE20]
          if (cyc != 5'h00) begin
            next_cyc = cyc - 5'h01;
          end else if (core_done_i) begin
            next_state = ADTR_IDLE;
            next_busy  = 1'b0;
            next_first = 1'b0;
          end
        end
      end
    endcase
    if (!next_en) begin
      next_state = ADTR_IDLE; // Abort [RULE18]
      next_busy  = 1'b0;
    end
  end

  // Result capture blocked while high byte read is pending [RULE8]
  always_comb begin
    next_result = result;
    next_locked = locked;
    if (finish && !locked) begin
      next_result = core_result_i; // [RULE1]
    end
    if (rd_i && addr_i == ADTR_OFS_RES_L) begin
      next_locked = 1'b1; // [RULE8]
    end
    if (rd_i && addr_i == ADTR_OFS_RES_H) begin
      next_locked = 1'b0; // [RULE8]
    end
  end

  // Layout follows the live justify bit [RULE9]
  always_comb begin
    if (ctrl_b[ADTR_B_LEFT]) begin
      res_h = result[9:2]; // [RULE7]
      res_l = {result[1:0], 6'h00}; // [RULE7]
    end else begin
      res_h = {6'h00, result[9:8]}; // [RULE6]
      res_l = result[7:0]; // [RULE6]
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        ADTR_OFS_DIDR:   next_rdata = didr;
        ADTR_OFS_CTRL_B: next_rdata = ctrl_b; // [RULE10]
        ADTR_OFS_RES_L:  next_rdata = res_l;
        ADTR_OFS_RES_H:  next_rdata = res_h;
        ADTR_OFS_CTRL_A: next_rdata = {en, busy, auto_en, done, ie, psel}; // [RULE19]
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_b    <= ADTR_RST_REG;
      didr      <= ADTR_RST_REG;
      en        <= 1'b0;
      auto_en   <= 1'b0;
      ie        <= 1'b0;
      psel      <= 3'h0;
      done      <= 1'b0;
      pdiv      <= 7'h00;
      state     <= ADTR_IDLE;
      busy      <= 1'b0;
      first     <= 1'b1;
      cyc       <= 5'h00;
      started   <= 1'b0;
      result    <= 10'h000;
      locked    <= 1'b0;
      trig_prev <= 1'b0;
      sel_prev  <= 3'h0;
      rdata_o   <= 8'h00;
      pin_s1    <= 4'h0;
      pin_s2    <= 4'h0;
      pin_read_o <= 4'h0;
    end else begin
      ctrl_b    <= next_ctrl_b;
      didr      <= next_didr;
      en        <= next_en;
      auto_en   <= next_auto_en;
      ie        <= next_ie;
      psel      <= next_psel;
      done      <= next_done;
      pdiv      <= next_pdiv;
      state     <= next_state;
      busy      <= next_busy;
      first     <= next_first;
      cyc       <= next_cyc;
      started   <= next_started;
      result    <= next_result;
      locked    <= next_locked;
      trig_prev <= next_trig_prev;
      sel_prev  <= next_sel_prev;
      rdata_o   <= next_rdata;
      pin_s1    <= pin_level_i;
      pin_s2    <= pin_s1;
      pin_read_o <= pin_s2 & ~didr[3:0]; // [RULE16]
    end
  end

  assign irq_o           = done && ie && global_irq_en_i; // [RULE2]
  assign conv_tick_o     = tick;
  assign core_start_o    = state == ADTR_CONV && tick && !started; // [RULE20]
  assign pin_input_off_o = didr[3:0]; // [RULE16]

  AST_IRQ_GATE: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq_o |-> done && ie && global_irq_en_i) else $error("irq without cause"); // [RULE2]
  AST_DONE_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
    finish |=> done) else $error("done not set"); // [RULE1]
  AST_ACK_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
    vector_ack_i && !finish |=> !done) else $error("ack left done"); // [RULE3]
  AST_W1C: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && addr_i == ADTR_OFS_CTRL_A && !wdata_i[ADTR_A_DONE] && !vector_ack_i && done
    |=> done) else $error("zero write cleared done"); // [RULE4]
  AST_ABORT: assert property (@(posedge mclk_i) disable iff (rst_i)
    !en |-> !busy) else $error("busy while off"); // [RULE18]
  AST_LOCK: assert property (@(posedge mclk_i) disable iff (rst_i)
    locked && !(rd_i && addr_i == ADTR_OFS_RES_H) |=> $stable(result))
    else $error("result changed while locked"); // [RULE8]
  AST_NO_AUTO: assert property (@(posedge mclk_i) disable iff (rst_i)
    !auto_en |-> !trig_edge) else $error("trigger without auto"); // [RULE11]
  AST_PIN_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    |(pin_read_o & didr[3:0]) |-> $changed(didr)) else $error("disabled pin reads one"); // [RULE16]
  AST_RIGHT: assert property (@(posedge mclk_i) disable iff (rst_i)
    !ctrl_b[ADTR_B_LEFT] |-> res_h[7:2] == 6'h00) else $error("high bits set"); // [RULE6]

  // Flag holds unless ack or a one written to it
  AST_DONE_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE1]
    done && !vector_ack_i && !(wr_i && addr_i == ADTR_OFS_CTRL_A && wdata_i[ADTR_A_DONE]) |=> done)
    else $error("done dropped by itself");

  AST_W1C_CLR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE4]
    wr_i && addr_i == ADTR_OFS_CTRL_A && wdata_i[ADTR_A_DONE] && !finish |=> !done)
    else $error("one write left done");

  AST_IRQ_ON: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE2]
    done && ie && global_irq_en_i |-> irq_o)
    else $error("irq missing");

  AST_LEFT_H: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE7]
    ctrl_b[ADTR_B_LEFT] |-> res_h == result[9:2])
    else $error("left high layout wrong");

  AST_LEFT_L: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE7]
    ctrl_b[ADTR_B_LEFT] |-> res_l[5:0] == 6'h00 && res_l[7:6] == result[1:0])
    else $error("left low layout wrong");

  AST_RIGHT_L: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE6]
    !ctrl_b[ADTR_B_LEFT] |-> res_l == result[7:0] && res_h[1:0] == result[9:8])
    else $error("right layout wrong");

  AST_RSV_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE10]
    wr_i && addr_i == ADTR_OFS_CTRL_B |=> ctrl_b[ADTR_B_RSV5] == $past(wdata_i[ADTR_B_RSV5]) &&
    ctrl_b[ADTR_B_RSV3] == $past(wdata_i[ADTR_B_RSV3]))
    else $error("reserved bit lost");

  // Switching into free running must not look like an edge
  AST_FREE_SWITCH: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE14]
    ctrl_b[2:0] == ADTR_TRIG_FREE && sel_prev != ADTR_TRIG_FREE |-> !trig_edge)
    else $error("switch to free running triggered");

  AST_EDGE_START: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE17]
    trig_edge && state == ADTR_IDLE && next_en |=> busy)
    else $error("edge did not start");

  AST_SW_START: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE19]
    sw_start && state == ADTR_IDLE && next_en |=> busy)
    else $error("start write ignored");

  AST_BUSY_CONV: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE19]
    busy |-> state == ADTR_CONV)
    else $error("busy outside conversion");

  AST_FIRST_LEN: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE19]
    state == ADTR_IDLE && start_req && first |=> cyc == ADTR_FIRST_CYC - 5'h01)
    else $error("first conversion length wrong");

  AST_TICK_EN: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE5]
    conv_tick_o |-> en)
    else $error("tick while off");

  // Codes 0 and 1 never tick on two edges in a row
  AST_DIV2: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE5]
    tick && psel <= 3'h1 |=> !tick)
    else $error("divide by two broken");

  AST_START_BUSY: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE20]
    core_start_o |-> busy && en)
    else $error("core start while idle");

  AST_OFF_NO_START: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE18]
    $fell(en) |-> !busy)
    else $error("conversion survived disable");

  AST_AUTO_OFF: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE11]
    !auto_en && !sw_start |-> !start_req)
    else $error("start without auto or write");

  AST_LOCK_SET: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE8]
    rd_i && addr_i == ADTR_OFS_RES_L |=> locked)
    else $error("low read did not lock");

  AST_LOCK_CLR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE8]
    rd_i && addr_i == ADTR_OFS_RES_H |=> !locked)
    else $error("high read did not unlock");

  // Read data stands one cycle only
  AST_RDATA_IDLE: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE10]
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data without read");

  AST_PIN_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE16]
    $stable(didr) |-> (pin_read_o & didr[3:0]) == 4'h0)
    else $error("disabled pin reads one");

  AST_OFF_OUT: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE16]
    pin_input_off_o == didr[3:0])
    else $error("input disable output wrong");

  COV_CONV: cover property (@(posedge mclk_i) disable iff (rst_i) finish);
  COV_AUTO: cover property (@(posedge mclk_i) disable iff (rst_i) trig_edge && state == ADTR_IDLE);
  COV_LOCK: cover property (@(posedge mclk_i) disable iff (rst_i) locked && finish);
  COV_IRQ:  cover property (@(posedge mclk_i) disable iff (rst_i) irq_o ##1 vector_ack_i);
  COV_FREE: cover property (@(posedge mclk_i) disable iff (rst_i) trig_edge && ctrl_b[2:0] == ADTR_TRIG_FREE);
endmodule : adtr_core

// File: adtr_core_model.sv
/* Analog core stand-in: latches a value at start, answers from tick 13 on.
   Assumes start and tick pulses come from the control block on mclk_i. */
`timescale 1ns/1ps
module adtr_core_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       start_i,
  input  wire logic [9:0] value_i,
  output logic      [9:0] result_o,
  output logic            done_o
);
  logic [4:0] cnt;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt      <= 5'h00;
      result_o <= 10'h000;
    end else if (start_i) begin
      cnt      <= 5'h01;
      result_o <= value_i;
    end else if (tick_i && cnt != 5'h00 && cnt != 5'h1f) begin
      cnt <= cnt + 5'h01;
    end
  end
  // Done on every tick from 13 on: serves both conversion lengths
  assign done_o = tick_i && cnt >= 5'h0c;
endmodule : adtr_core_model

// File: adtr_core_tb.sv
/* Self-checking bench for the converter control block.
   Assumes adtr_core_model as the analog core and the package constants. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module adtr_core_tb;
  import adtr_pkg::*;
  logic       mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic       global_irq_en_i = 1'b1, vector_ack_i = 1'b0;
  logic       irq_o, conv_tick_o, core_start_o, core_done_i;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [6:0] trig_flags_i = 7'h00;
  logic [9:0] core_result_i, conv_value = 10'h000;
  logic [3:0] pin_level_i = 4'h0, pin_read_o, pin_input_off_o;
  int         fail_count = 0, total_checks = 0;

  adtr_core DUT (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .global_irq_en_i,
    .vector_ack_i, .trig_flags_i, .irq_o, .conv_tick_o, .core_start_o, .core_result_i,
    .core_done_i, .pin_level_i, .pin_read_o, .pin_input_off_o);
  adtr_core_model u_core (.mclk_i, .rst_i, .tick_i(conv_tick_o), .start_i(core_start_o),
    .value_i(conv_value), .result_o(core_result_i), .done_o(core_done_i));

  initial forever #10 mclk_i = ~mclk_i;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic timeout();
    `CHK(1'b0, 1'b1)
    print_verdict();
  endtask : timeout

  // Each access ends on an edge that the next one skips, so no strobe is set twice at once
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask : rd

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask : chk_rd

  function automatic logic [7:0] exp_byte(logic [9:0] v, logic left, logic hi);
    if (left) return hi ? v[9:2] : {v[1:0], 6'h00};
    return hi ? {6'h00, v[9:8]} : v[7:0];
  endfunction : exp_byte

  // Low byte first: the high read releases the capture lock
  task automatic chk_res(input logic [9:0] v, input logic left);
    chk_rd(ADTR_OFS_RES_L, exp_byte(v, left, 1'b0));
    chk_rd(ADTR_OFS_RES_H, exp_byte(v, left, 1'b1));
  endtask : chk_res

  task automatic conv_wait(output int c);
    logic [7:0] d;
    c = 1;
    do begin
      rd(ADTR_OFS_CTRL_A, d);
      c += 2;
    end while (d[ADTR_A_START] && c < 800);
    if (c >= 800) timeout();
  endtask : conv_wait

  task automatic tick_gap(output int g);
    repeat (2) begin
      g = 0;
      do begin
        @(negedge mclk_i);
        g++;
      end while (!conv_tick_o && g < 300);
    end
    if (g >= 300) timeout();
  endtask : tick_gap

  task automatic wait_start(output logic s);
    s = 1'b0;
    repeat (12) begin
      @(negedge mclk_i);
      if (core_start_o === 1'b1) s = 1'b1;
    end
  endtask : wait_start

  initial begin
    logic [9:0] v;
    logic       s;
    int         c;
    void'($urandom(5));
    pin_level_i <= 4'($urandom);
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) chk_rd(3'(a), ADTR_RST_REG);
    $display("end reset");
    wr(ADTR_OFS_CTRL_B, 8'hff);
    chk_rd(ADTR_OFS_CTRL_B, 8'h7f);
    wr(ADTR_OFS_CTRL_B, 8'h28);
    chk_rd(ADTR_OFS_CTRL_B, 8'h28);
    wr(ADTR_OFS_DIDR, 8'hff);
    chk_rd(ADTR_OFS_DIDR, 8'h3f);
    wr(ADTR_OFS_DIDR, 8'h05);
    repeat (4) @(negedge mclk_i);
    `CHK(pin_read_o, pin_level_i & 4'ha)
    `CHK(pin_input_off_o, 4'h5)
    $display("end registers");
    v = 10'($urandom);
    @(posedge mclk_i) conv_value <= v;
    wr(ADTR_OFS_CTRL_A, 8'hc8);
    conv_wait(c);
    `CHK(c inside {[46:58]}, 1'b1)
    chk_rd(ADTR_OFS_CTRL_A, 8'h98);
    `CHK(irq_o, 1'b1)
    chk_res(v, 1'b0);
    wr(ADTR_OFS_CTRL_B, 8'h10);
    chk_res(v, 1'b1);
    @(posedge mclk_i) global_irq_en_i <= 1'b0;
    @(negedge mclk_i);
    `CHK(irq_o, 1'b0)
    wr(ADTR_OFS_CTRL_A, 8'h88);
    chk_rd(ADTR_OFS_CTRL_A, 8'h98);
    wr(ADTR_OFS_CTRL_A, 8'h98);
    chk_rd(ADTR_OFS_CTRL_A, 8'h88);
    $display("end first conversion");
    chk_rd(ADTR_OFS_RES_L, exp_byte(v, 1'b1, 1'b0));
    @(posedge mclk_i) conv_value <= ~v;
    wr(ADTR_OFS_CTRL_A, 8'hc8);
    conv_wait(c);
    `CHK(c inside {[22:34]}, 1'b1)
    chk_rd(ADTR_OFS_CTRL_A, 8'h98);
    chk_rd(ADTR_OFS_RES_H, exp_byte(v, 1'b1, 1'b1));
    @(posedge mclk_i) vector_ack_i <= 1'b1;
    @(posedge mclk_i) vector_ack_i <= 1'b0;
    chk_rd(ADTR_OFS_CTRL_A, 8'h88);
    v = 10'($urandom);
    @(posedge mclk_i) conv_value <= v;
    wr(ADTR_OFS_CTRL_A, 8'hc8);
    conv_wait(c);
    chk_res(v, 1'b1);
    wr(ADTR_OFS_CTRL_A, 8'hd8);
    repeat (5) @(posedge mclk_i);
    wr(ADTR_OFS_CTRL_A, 8'h08);
    chk_rd(ADTR_OFS_CTRL_A, 8'h08);
    repeat (60) @(posedge mclk_i);
    chk_rd(ADTR_OFS_CTRL_A, 8'h08);
    $display("end lock and abort");
    for (int k = 0; k < 8; k++) begin
      wr(ADTR_OFS_CTRL_A, 8'h80 | 8'(k));
      tick_gap(c);
      `CHK(c, (k < 2) ? 2 : (1 << k))
    end
    $display("end divider");
    wr(ADTR_OFS_CTRL_B, 8'h13);
    wr(ADTR_OFS_CTRL_A, 8'h88);
    @(posedge mclk_i) trig_flags_i <= 7'h04;
    wait_start(s);
    `CHK(s, 1'b0)
    for (int k = 1; k < 8; k++) begin
      @(posedge mclk_i) trig_flags_i <= 7'h00;
      wr(ADTR_OFS_CTRL_B, 8'h10 | 8'(k));
      wr(ADTR_OFS_CTRL_A, 8'ha8);
      @(posedge mclk_i) trig_flags_i <= 7'h7f ^ (7'h01 << (k - 1));
      wait_start(s);
      `CHK(s, 1'b0)
      @(posedge mclk_i) trig_flags_i <= 7'h7f;
      wait_start(s);
      `CHK(s, 1'b1)
      conv_wait(c);
    end
    @(posedge mclk_i) trig_flags_i <= 7'h01;
    wr(ADTR_OFS_CTRL_B, 8'h12);
    wr(ADTR_OFS_CTRL_B, 8'h11);
    wait_start(s);
    `CHK(s, 1'b1)
    conv_wait(c);
    wr(ADTR_OFS_CTRL_B, 8'h12);
    wr(ADTR_OFS_CTRL_B, 8'h10);
    wait_start(s);
    `CHK(s, 1'b0)
    wr(ADTR_OFS_CTRL_A, 8'hf8);
    c = 0;
    repeat (80) begin
      @(negedge mclk_i);
      if (core_start_o === 1'b1) c++;
    end
    `CHK(c >= 2, 1'b1)
    $display("end auto trigger");
    print_verdict();
  end
endmodule : adtr_core_tb
